// >>> pkg/trh_consts.svh
`ifndef TRH_CONSTS_SVH
`define TRH_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define TRH_WORD_W 16
`define TRH_ADDR_W 6
`define TRH_LAT_W 4

// ----------------------------------------------------------------------------
// Image layout and transceiver addresses
// ----------------------------------------------------------------------------
`define TRH_IMG_WORDS 32
`define TRH_IMG_LAST 6'h1f
`define TRH_PMA_ADDR 6'h20
`define TRH_ADDR_ZERO 6'h00
`define TRH_ADDR_ONE 6'h01

// ----------------------------------------------------------------------------
// Timing counts in clock cycles
// ----------------------------------------------------------------------------
`define TRH_LAT_ONE 4'h1
`define TRH_LAT_ZERO 4'h0
`define TRH_LAT_MAX 15
`define TRH_ERR_CYC 2
`define TRH_ERR_LAST 2'h1
`define TRH_ERR_ZERO 2'h0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TRH_WORD_RST 16'h0000

`endif

// >>> pkg/trh_pkg.sv
package trh_pkg;

  // --------------------------------------------------------------------------
  // Reconfiguration mode chosen by user logic
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    MODE_ANALOG = 1'h0,
    MODE_CHANNEL = 1'h1
  } trh_mode_type;

  // --------------------------------------------------------------------------
  // Controller states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [6:0] {
    S_PWR = 7'h01,
    S_OCAL = 7'h02,
    S_IDLE = 7'h04,
    S_FETCH = 7'h08,
    S_WRITE = 7'h10,
    S_READ = 7'h20,
    S_ERR = 7'h40
  } trh_state_type;

endpackage : trh_pkg

// >>> pkg/trh_if.sv
`timescale 1ns/1ns
`include "trh_consts.svh"

interface trh_if;
  import trh_pkg::*;

  logic write_all;
  logic read;
  trh_mode_type mode;
  logic [`TRH_WORD_W-1:0] pma_wdata;
  logic [`TRH_WORD_W-1:0] img_data;
  logic busy;
  logic data_valid;
  logic error;
  logic [`TRH_WORD_W-1:0] pma_rdata;
  logic [`TRH_ADDR_W-1:0] img_addr;

  modport dev (
    input write_all, read, mode, pma_wdata, img_data,
    output busy, data_valid, error, pma_rdata, img_addr
  );

  modport usr (
    output write_all, read, mode, pma_wdata, img_data,
    input busy, data_valid, error, pma_rdata, img_addr
  );

endinterface : trh_if

// >>> core/trh_ctrl.sv
`timescale 1ns/1ns
`include "trh_consts.svh"

module trh_ctrl
  import trh_pkg::*;
#(
  parameter bit CONT_WRITE = 1'b1,
  parameter int MIF_LAT = 2,
  parameter int PMA_PORTS = 1
) (
  input wire logic clk,
  input wire logic rstn,
  trh_if.dev hs,
  output logic ocal_start,
  input wire logic ocal_done,
  output logic xcvr_wr_en,
  output logic xcvr_rd_en,
  output logic [`TRH_ADDR_W-1:0] xcvr_addr,
  output logic [`TRH_WORD_W-1:0] xcvr_wdata,
  input wire logic [`TRH_WORD_W-1:0] xcvr_rdata,
  input wire logic xcvr_done
);

  // --------------------------------------------------------------------------
  // Configuration
  // --------------------------------------------------------------------------
  // Per-word writes fetch one word at a time, so the latency option is moot.
  localparam logic [`TRH_LAT_W-1:0] LAT_USE =
    CONT_WRITE ? MIF_LAT[`TRH_LAT_W-1:0] : `TRH_LAT_ONE;
  localparam bit RD_AVAIL = (PMA_PORTS > 0);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  trh_state_type state_ff;
  trh_state_type nxt_state;
  trh_mode_type mode_ff;
  logic [`TRH_LAT_W-1:0] lat_cnt_ff;
  logic [1:0] err_cnt_ff;
  logic [`TRH_ADDR_W-1:0] ptr_ff;
  logic [`TRH_ADDR_W-1:0] addr_ff;
  logic [`TRH_WORD_W-1:0] wdata_ff;
  logic [`TRH_WORD_W-1:0] rdata_ff;
  logic dv_ff;
  logic wr_en_ff;
  logic rd_en_ff;
  logic ocal_start_ff;
  logic wr_req;
  logic rd_req;
  logic bad_op;
  logic last_word;
  logic lat_done;

  function automatic logic in_xact(input trh_state_type s);
    return (s == S_FETCH) || (s == S_WRITE) || (s == S_READ);
  endfunction : in_xact

  // --------------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------------
  assign wr_req = hs.write_all;
  // Without any analog port the read strobe does not exist and is ignored.
  assign rd_req = hs.read && RD_AVAIL;
  // A strobe during a transaction, both strobes at once, or a read in a
  // channel mode cannot be served; each aborts to the error sequence.
  assign bad_op = (rd_req && (hs.mode == MODE_CHANNEL))
    || (wr_req && rd_req)
    || (in_xact(state_ff) && (wr_req || rd_req));
  assign last_word = (ptr_ff == `TRH_IMG_LAST);
  assign lat_done = (lat_cnt_ff == LAT_USE);

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_PWR: begin
        nxt_state = S_OCAL;
      end
      S_OCAL: begin
        if (ocal_done) begin
          nxt_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (bad_op) begin
          nxt_state = S_ERR;
        end else if (rd_req) begin
          nxt_state = S_READ;
        end else if (wr_req) begin
          nxt_state = (hs.mode == MODE_ANALOG) ? S_WRITE : S_FETCH;
        end
      end
      S_FETCH: begin
        if (bad_op) begin
          nxt_state = S_ERR;
        end else if (lat_done) begin
          nxt_state = S_WRITE;
        end
      end
      S_WRITE: begin
        if (bad_op) begin
          nxt_state = S_ERR;
        end else if (xcvr_done) begin
          if (CONT_WRITE && (mode_ff == MODE_CHANNEL) && !last_word) begin
            nxt_state = S_FETCH;
          end else begin
            nxt_state = S_IDLE;
          end
        end
      end
      S_READ: begin
        if (bad_op) begin
          nxt_state = S_ERR;
        end else if (xcvr_done) begin
          nxt_state = S_IDLE;
        end
      end
      S_ERR: begin
        if (err_cnt_ff == `TRH_ERR_LAST) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_PWR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= S_PWR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // --------------------------------------------------------------------------
  // Transaction bookkeeping
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_ff <= MODE_ANALOG;
    end else if ((state_ff == S_IDLE) && (wr_req || rd_req)) begin
      mode_ff <= hs.mode;
    end
  end

  // Counts cycles since the fetch address was presented.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lat_cnt_ff <= `TRH_LAT_ZERO;
    end else if (state_ff != S_FETCH) begin
      lat_cnt_ff <= `TRH_LAT_ZERO;
    end else begin
      lat_cnt_ff <= lat_cnt_ff + `TRH_LAT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      err_cnt_ff <= `TRH_ERR_ZERO;
    end else if (state_ff == S_ERR) begin
      err_cnt_ff <= err_cnt_ff + 2'h1;
    end else begin
      err_cnt_ff <= `TRH_ERR_ZERO;
    end
  end

  // An abort restarts the image, since a partial write leaves the channel
  // in an unknown setting and only a full rewrite recovers it.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ptr_ff <= `TRH_ADDR_ZERO;
    end else if (nxt_state == S_ERR) begin
      ptr_ff <= `TRH_ADDR_ZERO;
    end else if ((state_ff == S_WRITE) && xcvr_done && (mode_ff == MODE_CHANNEL)) begin
      ptr_ff <= last_word ? `TRH_ADDR_ZERO : ptr_ff + `TRH_ADDR_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wdata_ff <= `TRH_WORD_RST;
    end else if ((state_ff == S_IDLE) && wr_req && (hs.mode == MODE_ANALOG)) begin
      wdata_ff <= hs.pma_wdata;
    end else if ((state_ff == S_FETCH) && lat_done) begin
      wdata_ff <= hs.img_data;
    end
  end

  // --------------------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_ff <= `TRH_WORD_RST;
      dv_ff <= 1'b0;
    end else if ((state_ff == S_READ) && xcvr_done && !bad_op) begin
      rdata_ff <= xcvr_rdata;
      dv_ff <= 1'b1;
    end else if ((state_ff == S_IDLE) && (wr_req || rd_req)) begin
      dv_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Transceiver side strobes
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_en_ff <= 1'b0;
      rd_en_ff <= 1'b0;
      addr_ff <= `TRH_ADDR_ZERO;
    end else begin
      wr_en_ff <= (nxt_state == S_WRITE) && (state_ff != S_WRITE);
      rd_en_ff <= (nxt_state == S_READ) && (state_ff != S_READ);
      if ((nxt_state == S_WRITE) && (state_ff == S_FETCH)) begin
        addr_ff <= ptr_ff;
      end else if ((nxt_state != state_ff) && in_xact(nxt_state)) begin
        addr_ff <= `TRH_PMA_ADDR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ocal_start_ff <= 1'b0;
    end else begin
      ocal_start_ff <= (state_ff == S_PWR);
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Busy is decoded from the state so it drops in the very cycle the error
  // sequence starts.
  assign hs.busy = in_xact(state_ff) || (state_ff == S_OCAL);
  assign hs.error = (state_ff == S_ERR);
  assign hs.data_valid = dv_ff;
  assign hs.pma_rdata = rdata_ff;
  assign hs.img_addr = ptr_ff;
  assign ocal_start = ocal_start_ff;
  assign xcvr_wr_en = wr_en_ff;
  assign xcvr_rd_en = rd_en_ff;
  assign xcvr_addr = addr_ff;
  assign xcvr_wdata = wdata_ff;

endmodule : trh_ctrl

// >>> core/trh_user.sv
`timescale 1ns/1ns
`include "trh_consts.svh"

module trh_user
  import trh_pkg::*;
#(
  parameter bit CONT_WRITE = 1'b1,
  parameter int MIF_LAT = 2
) (
  input wire logic clk,
  input wire logic rstn,
  trh_if.usr hs,
  input wire logic req_write,
  input wire logic req_read,
  input wire trh_mode_type req_mode,
  input wire logic [`TRH_WORD_W-1:0] req_pma_wdata,
  input wire logic img_we,
  input wire logic [`TRH_ADDR_W-1:0] img_waddr,
  input wire logic [`TRH_WORD_W-1:0] img_wdata,
  output logic ready,
  output logic rd_valid,
  output logic [`TRH_WORD_W-1:0] rd_word,
  output logic err_seen,
  output logic cal_done
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  localparam int LAT_USE = CONT_WRITE ? MIF_LAT : 1;

  logic [`TRH_WORD_W-1:0] img_mem [0:`TRH_IMG_WORDS-1];
  logic [`TRH_WORD_W-1:0] pipe_ff [0:`TRH_LAT_MAX-1];
  logic pend_wr_ff;
  logic pend_rd_ff;
  logic wr_stb_ff;
  logic rd_stb_ff;
  logic seen_busy_ff;
  logic cal_done_ff;
  logic dv_prev_ff;
  logic err_prev_ff;
  logic rd_valid_ff;
  logic err_seen_ff;
  logic [`TRH_WORD_W-1:0] rd_word_ff;
  trh_mode_type mode_ff;
  logic [`TRH_WORD_W-1:0] pma_wdata_ff;
  logic can_issue;
  logic issue_wr;
  logic issue_rd;

  // --------------------------------------------------------------------------
  // Strobe issue
  // --------------------------------------------------------------------------
  // The strobe cycle itself is also blocked because busy rises only after it.
  assign can_issue = cal_done_ff && !hs.busy && !hs.error && !wr_stb_ff && !rd_stb_ff;
  assign issue_wr = pend_wr_ff && can_issue;
  assign issue_rd = pend_rd_ff && can_issue && !pend_wr_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_wr_ff <= 1'b0;
      pend_rd_ff <= 1'b0;
    end else begin
      pend_wr_ff <= (pend_wr_ff && !issue_wr) || req_write;
      pend_rd_ff <= (pend_rd_ff && !issue_rd) || req_read;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_stb_ff <= 1'b0;
      rd_stb_ff <= 1'b0;
    end else begin
      wr_stb_ff <= issue_wr;
      rd_stb_ff <= issue_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_ff <= MODE_ANALOG;
      pma_wdata_ff <= `TRH_WORD_RST;
    end else if (!wr_stb_ff && !rd_stb_ff) begin
      mode_ff <= req_mode;
      pma_wdata_ff <= req_pma_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Calibration tracking and read-back
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      seen_busy_ff <= 1'b0;
      cal_done_ff <= 1'b0;
    end else begin
      seen_busy_ff <= seen_busy_ff || hs.busy;
      cal_done_ff <= cal_done_ff || (seen_busy_ff && !hs.busy);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dv_prev_ff <= 1'b0;
      err_prev_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      err_seen_ff <= 1'b0;
      rd_word_ff <= `TRH_WORD_RST;
    end else begin
      dv_prev_ff <= hs.data_valid;
      err_prev_ff <= hs.error;
      rd_valid_ff <= hs.data_valid && !dv_prev_ff;
      err_seen_ff <= hs.error && !err_prev_ff;
      if (hs.data_valid) begin
        rd_word_ff <= hs.pma_rdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Image store with read latency
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (img_we) begin
      img_mem[img_waddr[4:0]] <= img_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < `TRH_LAT_MAX; i++) begin
        pipe_ff[i] <= `TRH_WORD_RST;
      end
    end else begin
      pipe_ff[0] <= img_mem[hs.img_addr[4:0]];
      for (int i = 1; i < `TRH_LAT_MAX; i++) begin
        pipe_ff[i] <= pipe_ff[i-1];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign hs.write_all = wr_stb_ff;
  assign hs.read = rd_stb_ff;
  assign hs.mode = mode_ff;
  assign hs.pma_wdata = pma_wdata_ff;
  assign hs.img_data = pipe_ff[LAT_USE-1];
  assign ready = can_issue && !pend_wr_ff && !pend_rd_ff;
  assign rd_valid = rd_valid_ff;
  assign rd_word = rd_word_ff;
  assign err_seen = err_seen_ff;
  assign cal_done = cal_done_ff;

endmodule : trh_user

// >>> bench/trh_checker.sv
`timescale 1ns/1ns
`include "trh_consts.svh"

module trh_checker
  import trh_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic write_all,
  input wire logic read,
  input wire trh_mode_type mode,
  input wire logic [`TRH_WORD_W-1:0] pma_wdata,
  input wire logic [`TRH_WORD_W-1:0] img_data,
  input wire logic busy,
  input wire logic data_valid,
  input wire logic error,
  input wire logic [`TRH_WORD_W-1:0] pma_rdata,
  input wire logic [`TRH_ADDR_W-1:0] img_addr
);
  // ---------------------------------------------------------------------------
  // Idle tracking
  // ---------------------------------------------------------------------------
  // Calibration is the first busy period, so one busy cycle marks it as started.
  logic cal_ff;
  logic idle;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cal_ff <= 1'b0;
    end else if (busy) begin
      cal_ff <= 1'b1;
    end
  end

  assign idle = cal_ff && !busy && !error;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_wr_pulse_one: assert property (write_all |=> !write_all)
    else $error("write strobe longer than one cycle");
  a_rd_pulse_one: assert property (read |=> !read)
    else $error("read strobe longer than one cycle");
  a_strobe_when_idle: assert property ((write_all || read) |-> !busy && !error)
    else $error("strobe issued while busy");
  a_busy_first_low: assert property ($rose(rstn) |-> !busy ##1 busy)
    else $error("busy wrong after reset release");
  a_write_busy: assert property (write_all && !read && idle |=> busy)
    else $error("busy not raised by write");
  a_read_busy: assert property (read && !write_all && mode == MODE_ANALOG && idle
    |=> busy && !data_valid)
    else $error("busy not raised by read");
  a_err_two: assert property ($rose(error) |=> error ##1 !error)
    else $error("error pulse not two cycles");
  a_err_busy_low: assert property (error |-> !busy)
    else $error("busy high with error");
  a_err_source: assert property ($rose(error) |-> $past(write_all) || $past(read))
    else $error("error without a strobe");
  a_valid_hold: assert property (data_valid && !write_all && !read
    |=> data_valid && $stable(pma_rdata))
    else $error("read-back not held");
  a_valid_rise: assert property ($rose(data_valid) |-> $past(busy) && !busy)
    else $error("data valid not at read end");
  a_addr_step: assert property (busy && $past(busy) && img_addr != $past(img_addr)
    && img_addr != 6'h00 |-> img_addr == $past(img_addr) + 6'h01)
    else $error("image pointer skipped");
endmodule : trh_checker

// >>> bench/transceiver_reconfig_handshake_tb_top.sv
`timescale 1ns/1ns
`include "trh_consts.svh"

module transceiver_reconfig_handshake_tb_top;
  import trh_pkg::*;
  logic clk, rstn, ocal_done, req_write, req_read, img_we, ready, rd_valid, err_seen, cal_done;
  trh_mode_type req_mode;
  logic [15:0] req_pma_wdata, img_wdata, rd_word, xrdata, pma_val;
  logic [5:0] img_waddr;
  logic [1:0] ocal_st, wr_en, rd_en, done;
  logic [1:0] cnt [0:1];
  logic [5:0] xaddr [0:1];
  logic [5:0] laddr [0:1];
  logic [15:0] xwdata [0:1];
  int nwr [0:1];
  int nstb, mismatches, checks_done, i, k, n, e;

  trh_if bus();
  trh_if bus2();

  // Both ends of the main pair run on their default settings, which must agree.
  trh_user trh_user_i (
    .clk(clk), .rstn(rstn), .hs(bus), .req_write(req_write), .req_read(req_read),
    .req_mode(req_mode), .req_pma_wdata(req_pma_wdata), .img_we(img_we),
    .img_waddr(img_waddr), .img_wdata(img_wdata), .ready(ready), .rd_valid(rd_valid),
    .rd_word(rd_word), .err_seen(err_seen), .cal_done(cal_done));
  trh_ctrl trh_ctrl_i (
    .clk(clk), .rstn(rstn), .hs(bus), .ocal_start(ocal_st[0]), .ocal_done(ocal_done),
    .xcvr_wr_en(wr_en[0]), .xcvr_rd_en(rd_en[0]), .xcvr_addr(xaddr[0]),
    .xcvr_wdata(xwdata[0]), .xcvr_rdata(xrdata), .xcvr_done(done[0]));
  // Second end in per-word mode, driven directly so that faults can be forced on it.
  trh_ctrl #(.CONT_WRITE(1'b0)) trh_ctrl_i2 (
    .clk(clk), .rstn(rstn), .hs(bus2), .ocal_start(ocal_st[1]), .ocal_done(ocal_done),
    .xcvr_wr_en(wr_en[1]), .xcvr_rd_en(rd_en[1]), .xcvr_addr(xaddr[1]),
    .xcvr_wdata(xwdata[1]), .xcvr_rdata(xrdata), .xcvr_done(done[1]));
  trh_checker trh_checker_i (
    .clk(clk), .rstn(rstn), .write_all(bus.write_all), .read(bus.read), .mode(bus.mode),
    .pma_wdata(bus.pma_wdata), .img_data(bus.img_data), .busy(bus.busy),
    .data_valid(bus.data_valid), .error(bus.error), .pma_rdata(bus.pma_rdata),
    .img_addr(bus.img_addr));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function logic [15:0] img_word(input logic [5:0] a);
    return 16'hc300 ^ {10'h000, a};
  endfunction : img_word

  function logic bsy(input int j);
    return j ? bus2.busy : bus.busy;
  endfunction : bsy

  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task wait_busy(input int j, input logic lvl);
    for (int w = 0; w < 600 && bsy(j) !== lvl; w++) @(negedge clk);
    check("busy", bsy(j), lvl);
  endtask : wait_busy

  task pulse_usr(input logic w, input logic r);
    req_write <= w;
    req_read <= r;
    @(negedge clk);
    req_write <= 1'b0;
    req_read <= 1'b0;
  endtask : pulse_usr

  task drv2(input logic w, input logic r, input trh_mode_type m);
    bus2.write_all <= w;
    bus2.read <= r;
    bus2.mode <= m;
    @(negedge clk);
    bus2.write_all <= 1'b0;
    bus2.read <= 1'b0;
  endtask : drv2

  // ---------------------------------------------------------------------------
  // Transceiver model: done comes some cycles after each access, never at once.
  // ---------------------------------------------------------------------------
  always @(negedge clk) begin
    if (bus.write_all === 1'b1) nstb <= nstb + 1;
    bus2.img_data <= img_word(bus2.img_addr);
    for (int j = 0; j < 2; j++) begin
      done[j] <= (cnt[j] == 2'h1);
      cnt[j] <= (wr_en[j] || rd_en[j]) ? 2'h2 : (cnt[j] != 2'h0) ? cnt[j] - 2'h1 : 2'h0;
      if (wr_en[j]) begin
        nwr[j] <= nwr[j] + 1;
        laddr[j] <= xaddr[j];
        check("wdata", xwdata[j], xaddr[j] < 6'h20 ? img_word(xaddr[j]) : pma_val);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_power;
    rstn <= 1'b1;
    #1 check("busy_c0", {bsy(0), bsy(1)}, 2'h0);
    @(negedge clk);
    check("ocal_start", ocal_st, 2'h3);
    for (i = 0; i < 32; i++) begin
      img_we <= 1'b1;
      img_waddr <= i[5:0];
      img_wdata <= img_word(i[5:0]);
      bus2.write_all <= (i == 4);
      @(negedge clk);
    end
    img_we <= 1'b0;
    check("busy_cal", {bsy(0), bsy(1), bus2.error}, 3'h6);
    ocal_done <= 1'b1;
    @(negedge clk);
    ocal_done <= 1'b0;
    check("busy_fall", {bsy(0), bsy(1)}, 2'h0);
    @(negedge clk);
    check("cal_done", cal_done, 1'b1);
    $display("test t_power done");
  endtask : t_power

  task t_cont;
    n = nwr[0];
    e = nstb;
    req_mode <= MODE_CHANNEL;
    pulse_usr(1'b1, 1'b0);
    wait_busy(0, 1'b1);
    check("ready_busy", ready, 1'b0);
    wait_busy(0, 1'b0);
    check("words", nwr[0] - n, 32);
    check("strobes", nstb - e, 1);
    $display("test t_cont done");
  endtask : t_cont

  task t_pma;
    req_mode <= MODE_ANALOG;
    req_pma_wdata <= 16'h0a5c;
    pma_val = 16'h0a5c;
    xrdata <= 16'h3c5a;
    pulse_usr(1'b1, 1'b0);
    wait_busy(0, 1'b1);
    wait_busy(0, 1'b0);
    check("pma_addr", laddr[0], `TRH_PMA_ADDR);
    pulse_usr(1'b0, 1'b1);
    wait_busy(0, 1'b1);
    for (i = 0; i < 50 && rd_valid !== 1'b1; i++) @(negedge clk);
    check("rd_valid", rd_valid, 1'b1);
    repeat (3) @(negedge clk);
    check("rd_word", rd_word, 16'h3c5a);
    check("pma_rdata", bus.pma_rdata, 16'h3c5a);
    check("data_valid", bus.data_valid, 1'b1);
    $display("test t_pma done");
  endtask : t_pma

  task t_uerr;
    // A read asked for in a channel mode is refused by the device.
    req_mode <= MODE_CHANNEL;
    pulse_usr(1'b0, 1'b1);
    for (i = 0; i < 20 && err_seen !== 1'b1; i++) @(negedge clk);
    check("err_seen", err_seen, 1'b1);
    check("uerr_busy", {bus.busy, bus.error}, 2'h1);
    repeat (2) @(negedge clk);
    check("ready_after", {ready, bus.error}, 2'h2);
    $display("test t_uerr done");
  endtask : t_uerr

  task t_word;
    for (k = 0; k < 3; k++) begin
      n = nwr[1];
      drv2(1'b1, 1'b0, MODE_CHANNEL);
      wait_busy(1, 1'b1);
      wait_busy(1, 1'b0);
      check("word_n", nwr[1] - n, 1);
      check("word_addr", laddr[1], k);
    end
    $display("test t_word done");
  endtask : t_word

  task t_err;
    // Cases: read in channel mode, both strobes at once, a strobe inside a transfer.
    for (k = 0; k < 3; k++) begin
      drv2(k != 0, k < 2, trh_mode_type'(k != 1));
      if (k == 2) begin
        wait_busy(1, 1'b1);
        @(negedge clk);
        drv2(1'b1, 1'b0, MODE_CHANNEL);
      end
      e = 0;
      repeat (6) begin
        if (bus2.error === 1'b1) check("err_busy", bus2.busy, 1'b0);
        e += (bus2.error === 1'b1);
        @(negedge clk);
      end
      check("err_len", e, 2);
      check("abort_ptr", bus2.img_addr, `TRH_ADDR_ZERO);
      wait_busy(1, 1'b0);
    end
    $display("test t_err done");
  endtask : t_err

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rstn, ocal_done, req_write, req_read, img_we, img_waddr, img_wdata} = '0;
    {req_pma_wdata, xrdata, pma_val, cnt[0], cnt[1], nwr[0], nwr[1]} = '0;
    {nstb, mismatches, checks_done} = '0;
    req_mode = MODE_ANALOG;
    {bus2.write_all, bus2.read, bus2.pma_wdata} = '0;
    bus2.mode = MODE_CHANNEL;
    repeat (6) @(negedge clk);
    t_power();
    t_cont();
    t_pma();
    t_uerr();
    t_word();
    t_err();
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule : transceiver_reconfig_handshake_tb_top
